/* File: sswr_core.sv */
// supply supervisor with power-on hold, brown-out reset and watchdog
//
// What this block does
// - one reset output of selectable polarity, open-drain when active low and driven when active high, is active whenever the supply is below the trip threshold.
// - at power-up reset goes active at about one volt and stays for 200 ms after the supply is stable above threshold.
// - on a brown-out reset stays active while the supply falls, down to about one volt.
// - on recovery reset stays active until the supply has been above threshold for 200 ms.
// - while reset is active every serial read or write instruction is ignored.
// - with the watchdog enabled, select_and_kick_input held at one level past the timeout asserts reset.
// - every falling edge of select_and_kick_input restarts the watchdog count.
// - the timeout comes from two nonvolatile watchdog period bits.
// - period codes 00, 01, 10 give 1.4 s, 600 ms, 200 ms and 11 disables the watchdog, the factory value.
// - period bits cannot change while write-protect is low and protect_lock_bit is high.
`timescale 1ns/10ps
module sswr_core
    import sswr_pkg::*;
#(
    parameter bit ACTIVE_HIGH = 1'b0,
    parameter int unsigned MS_CYC = CYC_PER_MS,
    parameter int unsigned HOLD_T = HOLD_MS,
    parameter int unsigned WDT_SLOW_T = WDT_SLOW_MS,
    parameter int unsigned WDT_MID_T = WDT_MID_MS,
    parameter int unsigned WDT_FAST_T = WDT_FAST_MS
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // supply comparators, asynchronous
    input wire logic supply_above_1v_i,
    input wire logic supply_above_trip_i,
    // pins from the host
    input wire logic select_and_kick_input_i,
    input wire logic write_protect_n_i,
    // serial instruction request from the memory front end
    input wire logic instr_req_i,
    output logic instr_accept_o,
    // status register write of period and lock bits
    input wire logic wsr_req_i,
    input wire logic [1:0] wsr_period_i,
    input wire logic wsr_lock_i,
    output logic [1:0] watchdog_period_o,
    output logic protect_lock_bit_o,
    // reset pin: output, and enable that is low while pulling
    output logic reset_pin_o,
    output logic reset_pin_oe_n_o,
    output logic reset_active_o,
    output logic watchdog_fired_o
);
    initial
    begin
        if (MS_CYC < 1 || HOLD_T < 1 || WDT_FAST_T < 1)
            $error("timing parameters must be at least one");
        if (WDT_SLOW_T >= 32'hFFFF || HOLD_T >= 32'hFFFF)
            $error("timing parameters too large");
    end

    // reset release through two flip-flops
    logic rs1_r;
    logic rs2_r;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rs1_r <= 1'b0;
            rs2_r <= 1'b0;
        end
        else
        begin
            rs1_r <= 1'b1;
            rs2_r <= rs1_r;
        end
    end
    wire logic rst_n = rs2_r;

    // two-stage synchronisers for asynchronous inputs
    logic [3:0] sy1_r;
    logic [3:0] sy2_r;
    wire logic [3:0] raw = {supply_above_1v_i, supply_above_trip_i,
        select_and_kick_input_i, write_protect_n_i};
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // idle levels: select and protect high, so no false edge
            sy1_r <= 4'h3;
            sy2_r <= 4'h3;
        end
        else
        begin
            sy1_r <= raw;
            sy2_r <= sy1_r;
        end
    end
    wire logic v1v = sy2_r[3];
    wire logic supply_trip_threshold = sy2_r[2];
    wire logic kick = sy2_r[1];
    wire logic wp_n = sy2_r[0];

    // millisecond tick divider
    sswr_tick_if tk ();
    sswr_ms_tick #(.DIV(MS_CYC)) u_tick (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .tk(tk)
    );

    // period and lock bits; registers stand in for nonvolatile cells
    logic [1:0] wdp_r;
    logic [1:0] wdp_nxt;
    logic lock_r;
    logic lock_nxt;
    logic st_active;
    always_comb
    begin
        wdp_nxt = wdp_r;
        lock_nxt = lock_r;
        // locked when protect pin low and lock bit set; refused under reset
        if (wsr_req_i && !st_active && !(lock_r && !wp_n))
        begin
            wdp_nxt = wsr_period_i;
            lock_nxt = wsr_lock_i;
        end
    end

    // supervisor state and counters
    sswr_state_type st_r;
    sswr_state_type st_nxt;
    logic [CNT_W-1:0] hold_r;
    logic [CNT_W-1:0] hold_nxt;
    logic [CNT_W-1:0] wd_r;
    logic [CNT_W-1:0] wd_nxt;
    logic kick_d_r;
    logic kick_d_nxt;
    logic fired_r;
    logic fired_nxt;
    logic [CNT_W-1:0] wd_lim;
    logic fall;
    logic rise;

    // timeout limit decoded from the period code
    always_comb
    begin
        case (wdp_r)
            WDP_SLOW: wd_lim = CNT_W'(WDT_SLOW_T);
            WDP_MID: wd_lim = CNT_W'(WDT_MID_T);
            WDP_FAST: wd_lim = CNT_W'(WDT_FAST_T);
            default: wd_lim = '0;
        endcase
    end

    assign fall = kick_d_r && !kick;
    assign rise = !kick_d_r && kick;
    // pin edges count only while running: chip-select traffic during
    // the hold must not stretch the release
    assign tk.clear = (fall || rise) && !st_active;

    // next state: supply drives everything, the watchdog only while running
    always_comb
    begin
        st_nxt = st_r;
        hold_nxt = hold_r;
        wd_nxt = wd_r;
        kick_d_nxt = kick;
        fired_nxt = fired_r;
        case (st_r)
            SSWR_OFF:
            begin
                hold_nxt = '0;
                // reset active from about one volt onward
                if (v1v)
                    st_nxt = SSWR_HOLD;
            end
            SSWR_HOLD:
            begin
                if (!v1v)
                    st_nxt = SSWR_OFF;
                else if (!supply_trip_threshold)
                    hold_nxt = '0;
                else if (hold_r >= CNT_W'(HOLD_T))
                begin
                    st_nxt = SSWR_RUN;
                    wd_nxt = '0;
                end
                else if (tk.tick)
                    hold_nxt = hold_r + 32'h1;
            end
            SSWR_RUN:
            begin
                fired_nxt = 1'b0;
                hold_nxt = '0;
                // any level change restarts the count; the edge defines
                // the kick, a rise only ends a stuck-low stretch
                if (tk.clear)
                    wd_nxt = '0;
                else if (tk.tick)
                    wd_nxt = wd_r + 32'h1;
                if (!supply_trip_threshold || !v1v)
                    st_nxt = SSWR_HOLD;
                else if (wdp_r != WDP_OFF && !tk.clear
                         && wd_r >= wd_lim)
                begin
                    st_nxt = SSWR_HOLD;
                    fired_nxt = 1'b1;
                end
            end
            default:
                st_nxt = SSWR_OFF;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= SSWR_OFF;
            hold_r <= '0;
            wd_r <= '0;
            kick_d_r <= 1'b1;
            fired_r <= 1'b0;
            wdp_r <= WDP_RESET;
            lock_r <= LOCK_RESET;
        end
        else
        begin
            st_r <= st_nxt;
            hold_r <= hold_nxt;
            wd_r <= wd_nxt;
            kick_d_r <= kick_d_nxt;
            fired_r <= fired_nxt;
            wdp_r <= wdp_nxt;
            lock_r <= lock_nxt;
        end
    end

    // reset active in both off and hold; only the run state releases the pin
    assign st_active = (st_r != SSWR_RUN);
    // instructions refused while reset is active
    assign instr_accept_o = instr_req_i && !st_active;
    assign reset_active_o = st_active;
    assign watchdog_fired_o = fired_r;
    assign watchdog_period_o = wdp_r;
    assign protect_lock_bit_o = lock_r;
    // open drain: pull only when the active level is low
    assign reset_pin_o = ACTIVE_HIGH ? st_active : 1'b0;
    assign reset_pin_oe_n_o = ACTIVE_HIGH ? 1'b0 : !st_active;
endmodule

/* File: sswr_core_sva.sv */
// assertion checker for the supply supervisor core
`timescale 1ns/10ps
module sswr_core_sva
    import sswr_pkg::*;
#(
    parameter bit ACTIVE_HIGH = 1'b0,
    parameter int unsigned MS_CYC = CYC_PER_MS,
    parameter int unsigned HOLD_T = HOLD_MS,
    parameter int unsigned WDT_SLOW_T = WDT_SLOW_MS,
    parameter int unsigned WDT_MID_T = WDT_MID_MS,
    parameter int unsigned WDT_FAST_T = WDT_FAST_MS
)
(
    // clock, reset and inputs
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic supply_above_1v_i,
    input wire logic supply_above_trip_i,
    input wire logic select_and_kick_input_i,
    input wire logic write_protect_n_i,
    input wire logic instr_req_i,
    // outputs under watch
    input wire logic instr_accept_o,
    input wire logic [1:0] watchdog_period_o,
    input wire logic protect_lock_bit_o,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe_n_o,
    input wire logic reset_active_o,
    input wire logic watchdog_fired_o
);
    logic kick_q_r;
    int quiet_r;
    int up_r;
    int lim;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // timeout in cycles; off is put out of reach
    always_comb
    begin
        case (watchdog_period_o)
            WDP_FAST: lim = int'(WDT_FAST_T * MS_CYC);
            WDP_MID: lim = int'(WDT_MID_T * MS_CYC);
            WDP_SLOW: lim = int'(WDT_SLOW_T * MS_CYC);
            default: lim = 32'h3FFFFFFF;
        endcase
    end
    // quiet time on the pin, and time with both supplies good
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            kick_q_r <= 1'b1;
            quiet_r <= 0;
            up_r <= 0;
        end
        else
        begin
            kick_q_r <= select_and_kick_input_i;
            quiet_r <= (kick_q_r != select_and_kick_input_i ||
                reset_active_o) ? 0 : quiet_r + 1;
            up_r <= (supply_above_1v_i && supply_above_trip_i) ? up_r + 1 : 0;
        end
    end
    // five samples cover the two-flop synchroniser and the state flop
    sequence trip_low_s;
        !supply_above_trip_i [*5];
    endsequence
    sequence low_1v_s;
        !supply_above_1v_i [*5];
    endsequence
    accept_gate_a: assert property (
        instr_accept_o == (instr_req_i && !reset_active_o))
        else $error("accept gate wrong");
    pin_level_a: assert property (
        reset_active_o == (ACTIVE_HIGH ? reset_pin_o :
        !reset_pin_oe_n_o && !reset_pin_o)) else $error("reset pin wrong");
    trip_low_a: assert property (trip_low_s |-> reset_active_o)
        else $error("no reset below trip");
    low_1v_a: assert property (low_1v_s |-> reset_active_o)
        else $error("no reset below 1v");
    hold_len_a: assert property (
        $fell(reset_active_o) |-> up_r >= int'((HOLD_T - 1) * MS_CYC))
        else $error("hold too short");
    wd_bound_a: assert property (
        !reset_active_o |-> quiet_r <= lim + 6)
        else $error("watchdog late");
    wd_early_a: assert property (
        $rose(watchdog_fired_o) |-> quiet_r >= lim - int'(MS_CYC))
        else $error("watchdog early");
    lock_hold_a: assert property (
        (protect_lock_bit_o && !write_protect_n_i) [*3]
        |=> $stable(watchdog_period_o)) else $error("locked bits moved");
endmodule

bind sswr_core sswr_core_sva #(.ACTIVE_HIGH(ACTIVE_HIGH), .MS_CYC(MS_CYC),
    .HOLD_T(HOLD_T), .WDT_SLOW_T(WDT_SLOW_T), .WDT_MID_T(WDT_MID_T),
    .WDT_FAST_T(WDT_FAST_T)) chk (.*);

/* File: sswr_host_model.sv */
// host processor model that kicks the watchdog while out of reset
`timescale 1ns/10ps
module sswr_host_model
#(
    parameter int GAP = 7
)
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic kick_en_i,
    input wire logic pulse_i,
    output logic kick_o
);
    int cnt = 0;
    initial kick_o = 1'b1;
    // one-cycle low pulse every GAP+1 cycles; a dead host just holds high
    always @(posedge clk_i)
    begin
        cnt <= (!reset_n_i || !kick_en_i || cnt == GAP) ? 0 : cnt + 1;
        // pulse_i is a programmer's select pulse, taken even in reset
        kick_o <= !(pulse_i || (reset_n_i && kick_en_i && cnt == GAP));
    end
endmodule

/* File: sswr_ms_tick.sv */
// divider that makes a one-cycle enable pulse every millisecond
`timescale 1ns/10ps
module sswr_ms_tick
    import sswr_pkg::*;
#(
    parameter int unsigned DIV = CYC_PER_MS
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // tick out, restart in
    sswr_tick_if.src tk
);
    initial
    begin
        if (DIV < 1)
            $error("divider must be at least one");
    end

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic tick_r;
    logic tick_nxt;

    // count down; clear realigns the phase so a restarted timeout is exact
    always_comb
    begin
        tick_nxt = 1'b0;
        cnt_nxt = cnt_r - 32'h1;
        if (tk.clear)
            cnt_nxt = CNT_W'(DIV - 1);
        else if (cnt_r == '0)
        begin
            cnt_nxt = CNT_W'(DIV - 1);
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tk.tick = tick_r;
endmodule

/* File: sswr_pkg.sv */
// shared constants for the supply supervisor and watchdog reset block
package sswr_pkg;
    // clock rate in Hz
    localparam int unsigned CLK_HZ = 10000000;
    // reset hold after the supply is stable, in ms
    localparam int unsigned HOLD_MS = 200;
    // watchdog timeouts in ms
    localparam int unsigned WDT_SLOW_MS = 1400;
    localparam int unsigned WDT_MID_MS = 600;
    localparam int unsigned WDT_FAST_MS = 200;
    // cycles per millisecond, derived from the clock rate
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned HOLD_CYC = HOLD_MS * CYC_PER_MS;
    localparam int unsigned WDT_SLOW_CYC = WDT_SLOW_MS * CYC_PER_MS;
    localparam int unsigned WDT_MID_CYC = WDT_MID_MS * CYC_PER_MS;
    localparam int unsigned WDT_FAST_CYC = WDT_FAST_MS * CYC_PER_MS;
    // watchdog period codes {high bit, low bit}
    localparam logic [1:0] WDP_SLOW = 2'h0;
    localparam logic [1:0] WDP_MID = 2'h1;
    localparam logic [1:0] WDP_FAST = 2'h2;
    localparam logic [1:0] WDP_OFF = 2'h3;
    // factory value of the period bits: watchdog disabled
    localparam logic [1:0] WDP_RESET = 2'h3;
    localparam logic LOCK_RESET = 1'b0;
    // counter width, enough for the longest count
    localparam int CNT_W = 32;
    // supervisor states
    typedef enum logic [1:0] {SSWR_OFF, SSWR_HOLD, SSWR_RUN} sswr_state_type;
endpackage

/* File: sswr_tick_if.sv */
// interface carrying the millisecond tick between the divider and the core
`timescale 1ns/10ps
interface sswr_tick_if;
    logic tick;
    logic clear;
    modport src (output tick, input clear);
    modport dst (input tick, output clear);
endinterface

/* File: test_sswr_core.sv */
// self-checking bench for the supply supervisor core
`timescale 1ns/10ps
module test_sswr_core;
    import sswr_pkg::*;
    localparam int MS = 10;
    localparam int HT = 3;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic a1v = 1'b0;
    logic trip = 1'b0;
    logic wp_n = 1'b1;
    logic ireq = 1'b1;
    logic wreq = 1'b0;
    logic [1:0] wper = 2'h0;
    logic wlock = 1'b0;
    logic ken = 1'b1;
    logic prog = 1'b0;
    logic pin_hi, oe_hi;
    logic kick, acc, pin, oe_n, ract, fired, lock, line;
    logic [1:0] per;
    logic [1:0] codes[3] = '{WDP_FAST, WDP_MID, WDP_SLOW};
    int tmo[3] = '{2, 5, 8};
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    // open-drain line with a pull-up
    assign line = oe_n ? 1'b1 : pin;
    sswr_core #(.MS_CYC(MS), .HOLD_T(HT), .WDT_SLOW_T(8), .WDT_MID_T(5),
        .WDT_FAST_T(2)) uut (.clk_i(clk), .rst_n_i(rst_n),
        .supply_above_1v_i(a1v), .supply_above_trip_i(trip),
        .select_and_kick_input_i(kick), .write_protect_n_i(wp_n),
        .instr_req_i(ireq), .instr_accept_o(acc), .wsr_req_i(wreq),
        .wsr_period_i(wper), .wsr_lock_i(wlock), .watchdog_period_o(per),
        .protect_lock_bit_o(lock), .reset_pin_o(pin),
        .reset_pin_oe_n_o(oe_n), .reset_active_o(ract),
        .watchdog_fired_o(fired));
    // active-high variant on the same inputs, for its pin levels
    sswr_core #(.ACTIVE_HIGH(1'b1), .MS_CYC(MS), .HOLD_T(HT),
        .WDT_SLOW_T(8), .WDT_MID_T(5), .WDT_FAST_T(2)) uut_hi (
        .clk_i(clk), .rst_n_i(rst_n),
        .supply_above_1v_i(a1v), .supply_above_trip_i(trip),
        .select_and_kick_input_i(kick), .write_protect_n_i(wp_n),
        .instr_req_i(ireq), .instr_accept_o(), .wsr_req_i(wreq),
        .wsr_period_i(wper), .wsr_lock_i(wlock), .watchdog_period_o(),
        .protect_lock_bit_o(), .reset_pin_o(pin_hi),
        .reset_pin_oe_n_o(oe_hi), .reset_active_o(),
        .watchdog_fired_o());
    sswr_host_model #(.GAP(7)) host (.clk_i(clk), .reset_n_i(line),
        .kick_en_i(ken), .pulse_i(prog), .kick_o(kick));
    initial forever #50 clk = ~clk;
    // hang guard, well above the roughly 900 cycles the run needs
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            err_total++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(string name, logic [1:0] exp, logic [1:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask
    // one-cycle status write; the bits land before the task returns
    task automatic wsr(logic [1:0] p, logic l);
        @(posedge clk);
        wreq <= 1'b1;
        wper <= p;
        wlock <= l;
        tick(1);
        wreq <= 1'b0;
        tick(1);
        #1;
    endtask
    // trip threshold step: select and protect held high, one select pulse;
    // the programming voltage sits on clock and data, outside this block
    task automatic supply_trip_threshold_seq();
        @(posedge clk);
        wp_n <= 1'b1;
        tick(3);
        prog <= 1'b1;
        tick(1);
        prog <= 1'b0;
        tick(3);
        #1;
    endtask
    // waits for the reset level and checks how many cycles it took
    task automatic wait_lvl(logic v, int lo, int hi);
        int n;
        n = 0;
        while (ract !== v && n < hi + 50)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("reset timing", 2'h1, {1'b0, n >= lo && n <= hi});
    endtask
    initial
    begin
        tick(4);
        rst_n <= 1'b1;
        tick(3);
        #1 chk("line low", 2'h0, {1'b0, line});
        chk("accept in reset", 2'h0, {1'b0, acc});
        chk("period", WDP_OFF, per);
        chk("lock", 2'h0, {1'b0, lock});
        chk("high pin set", 2'h1, {1'b0, pin_hi});
        chk("high pin driven", 2'h0, {1'b0, oe_hi});
        wsr(WDP_FAST, 1'b1);
        chk("write in reset", WDP_OFF, per);
        @(posedge clk);
        a1v <= 1'b1;
        trip <= 1'b1;
        wait_lvl(1'b0, (HT - 1) * MS, HT * MS + 8);
        chk("accept", 2'h1, {1'b0, acc});
        chk("line high", 2'h1, {1'b0, line});
        chk("high pin clear", 2'h0, {1'b0, pin_hi});
        @(posedge clk);
        trip <= 1'b0;
        wait_lvl(1'b1, 0, 5);
        @(posedge clk);
        a1v <= 1'b0;
        tick(40);
        #1 chk("below 1v", 2'h1, {1'b0, ract});
        @(posedge clk);
        a1v <= 1'b1;
        trip <= 1'b1;
        wait_lvl(1'b0, (HT - 1) * MS, HT * MS + 8);
        // each period: kicks keep it quiet, a dead host trips it
        for (int i = 0; i < 3; i++)
        begin
            wsr(codes[i], 1'b0);
            chk("period", codes[i], per);
            tick(100);
            #1 chk("kicked", 2'h0, {1'b0, ract});
            @(posedge clk);
            ken <= 1'b0;
            wait_lvl(1'b1, (tmo[i] - 1) * MS - 8, tmo[i] * MS + 8);
            tick(2);
            #1 chk("fired", 2'h1, {1'b0, fired});
            @(posedge clk);
            ken <= 1'b1;
            wait_lvl(1'b0, (HT - 1) * MS, HT * MS + 8);
        end
        wsr(WDP_FAST, 1'b1);
        chk("lock set", 2'h1, {1'b0, lock});
        @(posedge clk);
        wp_n <= 1'b0;
        tick(3);
        wsr(WDP_MID, 1'b0);
        chk("locked", WDP_FAST, per);
        @(posedge clk);
        wp_n <= 1'b1;
        tick(3);
        wsr(WDP_OFF, 1'b0);
        chk("unlocked", WDP_OFF, per);
        chk("lock clear", 2'h0, {1'b0, lock});
        @(posedge clk);
        ken <= 1'b0;
        supply_trip_threshold_seq();
        supply_trip_threshold_seq();
        chk("select pulses", 2'h0, {1'b0, ract});
        tick(150);
        #1 chk("disabled", 2'h0, {1'b0, ract});
        test_done();
    end
endmodule
